// File: rtl/dsm_pkg.sv
// Package of register map, field layout and carrier types for the debug signal bank mux
package dsm_pkg;
	localparam logic [3:0] DSM_OFF_BANK_SEL = 4'h0;
	localparam logic [3:0] DSM_OFF_STATUS = 4'h4;
	localparam int DSM_SEL_BANK_LSB = 0;
	localparam int DSM_SEL_DRIVE_BIT = 8;
	localparam int DSM_ST_PINS_LSB = 0;
	localparam int DSM_ST_BANKS_LSB = 8;
	localparam int DSM_ST_MODE_BIT = 16;
	localparam int DSM_ST_RANGE_BIT = 17;
	localparam int DSM_ST_DRIVING_BIT = 18;
	localparam logic [1:0] DSM_RESP_OKAY = 2'h0;
	localparam logic [1:0] DSM_RESP_DECERR = 2'h3;
	localparam logic [31:0] DSM_RDATA_RST = 32'h0000_0000;
	localparam logic DSM_SAMPLE_RST = 1'h0;

	typedef enum logic {
		DSM_MODE_TIMING,
		DSM_MODE_STATE
	} dsm_mode_t;

	typedef struct packed {
		logic drive;
		logic [7:0] bank;
	} dsm_ctrl_t;

	typedef struct packed {
		logic valid;
		logic [1:0] resp;
	} dsm_bresp_t;

	typedef struct packed {
		logic valid;
		logic [1:0] resp;
		logic [31:0] data;
	} dsm_rresp_t;

	localparam dsm_bresp_t DSM_B_RST = '{valid: 1'b0, resp: DSM_RESP_OKAY};
	localparam dsm_rresp_t DSM_R_RST = '{valid: 1'b0, resp: DSM_RESP_OKAY, data: DSM_RDATA_RST};
endpackage

// File: rtl/dsm_sample_reg.sv
// Sample-clock capture register for state mode
`timescale 1ns/10ps
module dsm_sample_reg #(
	parameter int WIDTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sample_clk_in,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q,
	output logic fire
);
	import dsm_pkg::*;

	logic s1_q, s2_q, s3_q;
	logic s1_d, s2_d, s3_d;
	logic [WIDTH-1:0] q_d;
	logic [WIDTH-1:0] q_q;

	always_comb begin
		s1_d = sample_clk_in;
		s2_d = s1_q;
		s3_d = s2_q;
		fire = s2_q & ~s3_q;
		q_d = fire ? d : q_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= DSM_SAMPLE_RST;
			s2_q <= DSM_SAMPLE_RST;
			s3_q <= DSM_SAMPLE_RST;
			q_q <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			q_q <= q_d;
		end
	end

	assign q = q_q;

	sequence s_sample_edge;
		fire;
	endsequence

	property p_capture_on_edge;
		@(posedge aclk) disable iff (!aresetn)
		s_sample_edge |=> (q == $past(d));
	endproperty
	a_capture_on_edge: assert property (p_capture_on_edge)
		else $error("sample register missed capture");

	property p_hold_between_edges;
		@(posedge aclk) disable iff (!aresetn)
		(!fire ##1 !fire) |-> $stable(q);
	endproperty
	a_hold_between_edges: assert property (p_hold_between_edges)
		else $error("sample register changed without sample edge");
endmodule

// File: rtl/dsm_top.sv
// Debug signal bank mux with AXI4-Lite bank selection
`timescale 1ns/10ps
module dsm_top #(
	parameter int PINS = 8,
	parameter int BANKS = 8,
	parameter dsm_pkg::dsm_mode_t MODE = dsm_pkg::DSM_MODE_TIMING,
	parameter bit PWRUP_DRIVE = 1'b0,
	parameter logic [7:0] PWRUP_BANK = 8'h00
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [BANKS-1:0][PINS-1:0] probe_in,
	input wire logic sample_clk_in,
	output logic [PINS-1:0] dbg_out,
	output logic [PINS-1:0] dbg_oe
);
	import dsm_pkg::*;

	localparam logic [7:0] PINS_B = 8'(PINS);
	localparam logic [7:0] BANKS_B = 8'(BANKS);
	localparam dsm_ctrl_t CTRL_RST = '{drive: PWRUP_DRIVE, bank: PWRUP_BANK};

	dsm_ctrl_t ctrl_q, ctrl_d;
	dsm_bresp_t b_q, b_d;
	dsm_rresp_t r_q, r_d;
	logic wr_go, rd_go, in_range, driving;
	logic [PINS-1:0] sel_bits;
	logic [PINS-1:0] pin_bits;
	logic [31:0] status_word;

	// Write takes address and data together once both are offered and no write response is still pending
	assign wr_go = s_axi_awvalid & s_axi_wvalid & ~b_q.valid;
	assign rd_go = s_axi_arvalid & ~r_q.valid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;

	always_comb begin
		in_range = ctrl_q.bank < BANKS_B;
		driving = ctrl_q.drive & in_range;
		status_word = '0;
		status_word[DSM_ST_PINS_LSB +: 8] = PINS_B;
		status_word[DSM_ST_BANKS_LSB +: 8] = BANKS_B;
		status_word[DSM_ST_MODE_BIT] = (MODE == DSM_MODE_STATE);
		status_word[DSM_ST_RANGE_BIT] = in_range;
		status_word[DSM_ST_DRIVING_BIT] = driving;
	end

	always_comb begin
		ctrl_d = ctrl_q;
		b_d = b_q;
		if (b_q.valid && s_axi_bready) begin
			b_d.valid = 1'b0;
		end
		if (wr_go) begin
			b_d.valid = 1'b1;
			b_d.resp = DSM_RESP_OKAY;
			if (s_axi_awaddr == DSM_OFF_BANK_SEL) begin
				if (s_axi_wstrb[0]) begin
					ctrl_d.bank = s_axi_wdata[DSM_SEL_BANK_LSB +: 8];
				end
				if (s_axi_wstrb[1]) begin
					ctrl_d.drive = s_axi_wdata[DSM_SEL_DRIVE_BIT];
				end
			end else if (s_axi_awaddr != DSM_OFF_STATUS) begin
				b_d.resp = DSM_RESP_DECERR;
			end
		end
	end

	always_comb begin
		r_d = r_q;
		if (r_q.valid && s_axi_rready) begin
			r_d.valid = 1'b0;
		end
		if (rd_go) begin
			r_d.valid = 1'b1;
			r_d.resp = DSM_RESP_OKAY;
			r_d.data = '0;
			if (s_axi_araddr == DSM_OFF_BANK_SEL) begin
				r_d.data[DSM_SEL_BANK_LSB +: 8] = ctrl_q.bank;
				r_d.data[DSM_SEL_DRIVE_BIT] = ctrl_q.drive;
			end else if (s_axi_araddr == DSM_OFF_STATUS) begin
				r_d.data = status_word;
			end else begin
				r_d.resp = DSM_RESP_DECERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RST;
			b_q <= DSM_B_RST;
			r_q <= DSM_R_RST;
		end else begin
			ctrl_q <= ctrl_d;
			b_q <= b_d;
			r_q <= r_d;
		end
	end

	assign s_axi_bvalid = b_q.valid;
	assign s_axi_bresp = b_q.resp;
	assign s_axi_rvalid = r_q.valid;
	assign s_axi_rresp = r_q.resp;
	assign s_axi_rdata = r_q.data;

	// Per-pin bank selection by the shared index
	genvar p;
	generate
		for (p = 0; p < PINS; p++) begin : g_pin
			always_comb begin
				sel_bits[p] = 1'b0;
				for (int b = 0; b < BANKS; b++) begin
					if (ctrl_q.bank == 8'(b)) begin
						sel_bits[p] = probe_in[b][p];
					end
				end
			end
		end
	endgenerate

	generate
		if (MODE == DSM_MODE_STATE) begin : g_state
			dsm_sample_reg #(.WIDTH(PINS)) u_sample (
				.aclk(aclk),
				.aresetn(aresetn),
				.sample_clk_in(sample_clk_in),
				.d(sel_bits),
				.q(pin_bits),
				.fire()
			);
		end else begin : g_timing
			assign pin_bits = sel_bits;
		end
	endgenerate

	assign dbg_out = driving ? pin_bits : '0;
	assign dbg_oe = {PINS{driving}};

	property p_param_range;
		@(posedge aclk) disable iff (!aresetn)
		(PINS >= 1 && PINS <= 255 && BANKS >= 1 && BANKS <= 255);
	endproperty
	a_param_range: assert property (p_param_range)
		else $error("pin or bank count outside 1 to 255");

	property p_powerup;
		@(posedge aclk)
		!aresetn |=> (ctrl_q == CTRL_RST && (dbg_oe != '0) == (PWRUP_DRIVE && PWRUP_BANK < BANKS_B));
	endproperty
	a_powerup: assert property (p_powerup)
		else $error("power-up pin state wrong");

	sequence s_bank_write;
		wr_go && s_axi_awaddr == DSM_OFF_BANK_SEL && s_axi_wstrb[0];
	endsequence

	property p_bank_write;
		@(posedge aclk) disable iff (!aresetn)
		s_bank_write |=> (ctrl_q.bank == $past(s_axi_wdata[7:0]));
	endproperty
	a_bank_write: assert property (p_bank_write)
		else $error("bank write not applied next cycle");

	property p_out_of_range;
		@(posedge aclk) disable iff (!aresetn)
		(ctrl_q.bank >= BANKS_B) |-> (dbg_oe == '0 && dbg_out == '0);
	endproperty
	a_out_of_range: assert property (p_out_of_range)
		else $error("pins driven with bank out of range");

	property p_timing_route;
		@(posedge aclk) disable iff (!aresetn)
		(MODE == DSM_MODE_TIMING && driving) |-> (dbg_out == probe_in[ctrl_q.bank] && dbg_oe == '1);
	endproperty
	a_timing_route: assert property (p_timing_route)
		else $error("pins do not show selected bank");

	property p_bresp_hold;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp));
	endproperty
	a_bresp_hold: assert property (p_bresp_hold)
		else $error("write response dropped before taken");

	property p_bresp_one_cycle;
		@(posedge aclk) disable iff (!aresetn)
		wr_go |=> s_axi_bvalid;
	endproperty
	a_bresp_one_cycle: assert property (p_bresp_one_cycle)
		else $error("write response late");

	property p_rdata_hold;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp));
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data dropped before taken");

	property p_status_read;
		@(posedge aclk) disable iff (!aresetn)
		(rd_go && s_axi_araddr == DSM_OFF_STATUS) |=> (s_axi_rdata[DSM_ST_DRIVING_BIT] == $past(driving));
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status read does not show driving state");
endmodule

// File: tb/dsm_la_model.sv
// Behavioural external logic analyzer sampling the debug pins
`timescale 1ns/10ps
module dsm_la_model #(
	parameter int PINS = 8
) (
	input wire logic [PINS-1:0] pins,
	input wire logic trig,
	output logic la_clk,
	output logic [PINS-1:0] cap_val,
	output logic cap_vld
);
	logic trig_q;
	// Own clock, offset so its edges never meet the design clock edges
	initial begin
		la_clk = 1'b0;
		cap_vld = 1'b0;
		trig_q = 1'b0;
		#1;
		forever #5 la_clk = ~la_clk;
	end
	// One capture per trigger, asynchronous to the device
	always @(posedge la_clk) begin
		trig_q <= trig;
		cap_vld <= trig && !trig_q;
		if (trig && !trig_q) begin
			cap_val <= pins;
		end
	end
endmodule

// File: tb/tb.sv
// Testbench for the debug signal bank mux
`timescale 1ns/10ps
`define CHK(nm, e, g) begin logic [33:0] ev, gv; ev = e; gv = g; checks_done++; if (gv !== ev) begin n_mismatch++; $display("ERROR %s exp %h got %h", nm, ev, gv); end end
module tb;
	import dsm_pkg::*;
	localparam int NB = 5;
	localparam int NP = 8;
	localparam bit PD = 1'b1;
	localparam logic [7:0] PB = 8'h02;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, trig = 0, sclk = 0;
	logic awready, wready, bvalid, arready, rvalid, cap_vld, la_clk;
	logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf;
	logic [NP-1:0] dout_st, doe_st, cap_val_st;
	logic cap_vld_st;
	wire [NP-1:0] pins_st;
	logic [7:0] sq[$];
	logic [31:0] wdata = 0, rdata;
	logic [1:0] bresp, rresp;
	logic [NB-1:0][7:0] probe = '0;
	logic [7:0] dout, doe, cap_val;
	wire [7:0] pins;
	int n_mismatch = 0, checks_done = 0;
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	logic [7:0] pq[$];
	// Undriven header pins float
	for (genvar i = 0; i < NP; i++) begin : g_pin
		assign pins[i] = doe[i] ? dout[i] : 1'bz;
		assign pins_st[i] = doe_st[i] ? dout_st[i] : 1'bz;
	end
	dsm_top #(.PINS(NP), .BANKS(NB), .PWRUP_DRIVE(PD), .PWRUP_BANK(PB)) DUT (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .probe_in(probe),
		.sample_clk_in(sclk), .dbg_out(dout), .dbg_oe(doe));
	// State-mode twin on the same bus; its handshakes match the timing-mode one
	dsm_top #(.PINS(NP), .BANKS(NB), .MODE(DSM_MODE_STATE), .PWRUP_DRIVE(PD), .PWRUP_BANK(PB)) DUT_ST (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(),
		.s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready), .probe_in(probe),
		.sample_clk_in(sclk), .dbg_out(dout_st), .dbg_oe(doe_st));
	dsm_la_model #(.PINS(NP)) LA (.pins(pins), .trig(trig), .la_clk(la_clk), .cap_val(cap_val), .cap_vld(cap_vld));
	dsm_la_model #(.PINS(NP)) LA_ST (.pins(pins_st), .trig(trig), .la_clk(), .cap_val(cap_val_st), .cap_vld(cap_vld_st));
	initial begin
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (bvalid && bready) `CHK("bresp", bq.pop_front(), bresp)
		if (rvalid && rready) `CHK("rdata", rq.pop_front(), {rresp, rdata})
	end
	always @(posedge la_clk) if (cap_vld) `CHK("pins", pq.pop_front(), cap_val)
	always @(posedge la_clk) if (cap_vld_st) `CHK("pins_st", sq.pop_front(), cap_val_st)
	task automatic finish_test;
		if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Host selection path over the register bus
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge aclk); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		repeat ($urandom % 3) @(posedge aclk);
		bready <= 1'b1;
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [33:0] e);
		rq.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		repeat ($urandom % 3) @(posedge aclk);
		rready <= 1'b1;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
	endtask
	// New random probes and a sample edge, then one capture per analyzer
	task automatic pin_chk(input int b, input bit dr);
		logic [63:0] r;
		r = {$urandom, $urandom};
		probe <= r[8*NB-1:0];
		sclk <= 1'b1;
		repeat (3) @(posedge aclk);
		pq.push_back((dr && b < NB) ? probe[b] : 8'hzz);
		sq.push_back((dr && b < NB) ? probe[b] : 8'hzz);
		trig <= 1'b1;
		repeat (2) @(posedge aclk);
		trig <= 1'b0;
		sclk <= 1'b0;
		@(posedge aclk);
	endtask
	initial begin
		void'($urandom(25773));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		pin_chk(2, 1'b1);
		rd(DSM_OFF_STATUS, {DSM_RESP_OKAY, 32'h0006_0508});
		wr(DSM_OFF_STATUS, 32'h0, DSM_RESP_OKAY);
		for (int b = 0; b <= NB; b++) begin
			wr(DSM_OFF_BANK_SEL, 32'h100 | b, DSM_RESP_OKAY);
			pin_chk(b, 1'b1);
		end
		rd(DSM_OFF_STATUS, {DSM_RESP_OKAY, 32'h0000_0508});
		wr(4'h8, 32'h102, DSM_RESP_DECERR);
		rd(DSM_OFF_BANK_SEL, {DSM_RESP_OKAY, 32'h0000_0105});
		wr(DSM_OFF_BANK_SEL, 32'h003, DSM_RESP_OKAY);
		pin_chk(3, 1'b0);
		wstrb <= 4'h1;
		wr(DSM_OFF_BANK_SEL, 32'h101, DSM_RESP_OKAY);
		wstrb <= 4'hf;
		rd(DSM_OFF_BANK_SEL, {DSM_RESP_OKAY, 32'h0000_0001});
		pin_chk(1, 1'b0);
		wr(DSM_OFF_BANK_SEL, 32'h104, DSM_RESP_OKAY);
		pin_chk(4, 1'b1);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		pin_chk(2, 1'b1);
		rd(DSM_OFF_STATUS, {DSM_RESP_OKAY, 32'h0006_0508});
		finish_test();
	end
	initial begin
		repeat (5000) @(posedge aclk);
		n_mismatch++;
		finish_test();
	end
endmodule
